// ==== hw/yof_regs.vh ====
// register offsets, field positions, reset values and code levels
// of the yuv output formatter; included by the formatter, the checker and the testbench
`ifndef YOF_REGS_VH
`define YOF_REGS_VH

// register byte offsets on apb
`define YOF_CTRL_OFS 12'h000
`define YOF_STRB_OFS 12'h004
`define YOF_WINH_OFS 12'h008
`define YOF_WINV_OFS 12'h00c
`define YOF_STAT_OFS 12'h010

// ctrl fields
`define YOF_FMT_LSB 0
`define YOF_FMT_MSB 1
`define YOF_BLACK_SHIFT_BIT 2
`define YOF_LEGACY_LVL_BIT 3
`define YOF_OFFSET_BIN_BIT 4
`define YOF_HALF_DRIVE_BIT 5
`define YOF_POLARITY_BIT 6
`define YOF_MODE_SEL_BIT 7
`define YOF_REQ_EN_BIT 8
`define YOF_REQ_SRC_BIT 9
`define YOF_BUS_ID_LSB 12
`define YOF_BUS_ID_MSB 14

// strobe fields
`define YOF_DELAY_LSB 0
`define YOF_DELAY_MSB 5
`define YOF_ADV_LSB 8
`define YOF_ADV_MSB 9

// window fields: start in low half, stop in high half
`define YOF_WSTART_LSB 0
`define YOF_WSTART_MSB 10
`define YOF_WSTOP_LSB 16
`define YOF_WSTOP_MSB 26

// reset value of every setting
`define YOF_RST_VAL 32'h0000_0000

// output format codes
`define YOF_FMT_LEG422 2'h0
`define YOF_FMT_ORT422 2'h1
`define YOF_FMT_ORT411 2'h2

// code levels
`define YOF_STD_Y_MIN 8'h10
`define YOF_STD_Y_MAX 8'hf0
`define YOF_STD_C_LIM 8'h70
`define YOF_LEG_Y_MIN 8'h20
`define YOF_LEG_Y_MAX 8'h7f
`define YOF_LEG_C_LIM 8'h7f
`define YOF_BLACK_STEP 8'h10
`define YOF_SIGN_FLIP 8'h80

`endif

// ==== hw/yof_formatter.v ====
// yuv output formatter: chroma packing, code levels, active-video
// strobe and 3-bit priority-bus arbitration, with an apb register file.
// assumes pixel inputs, line/field marks and the priority bus are all
// synchronous to pclk; pads resolve the three-state pins from the enables.
`timescale 1ns/10ps
`include "yof_regs.vh"

module yof_formatter (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] luma_in,
  input wire [7:0] u_in,
  input wire [7:0] v_in,
  input wire active_video_in,
  input wire line_start_in,
  input wire field_start_in,
  input wire [2:0] priority_bus_in,
  output reg [2:0] priority_bus_out,
  output reg priority_bus_oe,
  output reg [7:0] luma_out_bus,
  output reg [7:0] chroma_out_bus,
  output reg pixel_oe,
  output reg pixel_half_drive,
  output reg active_video_out
);

  ////////////////////////////////////////////////////////////////////
  // register file
  reg [31:0] ctrl_q;
  reg [31:0] strb_q;
  reg [31:0] winh_q;
  reg [31:0] winv_q;
  reg granted_q;
  reg [31:0] rd_d;
  reg hit_d;

  wire [1:0] fmt = ctrl_q[`YOF_FMT_MSB:`YOF_FMT_LSB];
  wire black_shift = ctrl_q[`YOF_BLACK_SHIFT_BIT];
  wire legacy_lvl = ctrl_q[`YOF_LEGACY_LVL_BIT];
  wire offset_bin = ctrl_q[`YOF_OFFSET_BIN_BIT];
  wire out_strobe_polarity = ctrl_q[`YOF_POLARITY_BIT];
  wire out_strobe_mode_sel = ctrl_q[`YOF_MODE_SEL_BIT];
  wire priority_request_enable = ctrl_q[`YOF_REQ_EN_BIT];
  wire priority_request_source = ctrl_q[`YOF_REQ_SRC_BIT];
  wire [2:0] bus_id = ctrl_q[`YOF_BUS_ID_MSB:`YOF_BUS_ID_LSB];
  wire [5:0] out_strobe_delay = strb_q[`YOF_DELAY_MSB:`YOF_DELAY_LSB];
  wire [1:0] out_strobe_advance = strb_q[`YOF_ADV_MSB:`YOF_ADV_LSB];
  wire [10:0] h_start = winh_q[`YOF_WSTART_MSB:`YOF_WSTART_LSB];
  wire [10:0] h_stop = winh_q[`YOF_WSTOP_MSB:`YOF_WSTOP_LSB];
  wire [10:0] v_start = winv_q[`YOF_WSTART_MSB:`YOF_WSTART_LSB];
  wire [10:0] v_stop = winv_q[`YOF_WSTOP_MSB:`YOF_WSTOP_LSB];

  // read mux and address decode
  always @* begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    if (paddr == `YOF_CTRL_OFS) begin
      rd_d = ctrl_q;
    end else if (paddr == `YOF_STRB_OFS) begin
      rd_d = strb_q;
    end else if (paddr == `YOF_WINH_OFS) begin
      rd_d = winh_q;
    end else if (paddr == `YOF_WINV_OFS) begin
      rd_d = winv_q;
    end else if (paddr == `YOF_STAT_OFS) begin
      rd_d = {27'h0000000, priority_bus_in, active_video_out, granted_q};
    end else begin
      hit_d = 1'b0;
    end
  end

  // one wait-free answer: ready raised by the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_d;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // writes land at the completing edge; all settings clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `YOF_RST_VAL;
      strb_q <= `YOF_RST_VAL;
      winh_q <= `YOF_RST_VAL;
      winv_q <= `YOF_RST_VAL;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == `YOF_CTRL_OFS) begin
        ctrl_q <= pwdata & 32'h0000_73ff;
      end else if (paddr == `YOF_STRB_OFS) begin
        strb_q <= pwdata & 32'h0000_033f;
      end else if (paddr == `YOF_WINH_OFS) begin
        winh_q <= pwdata & 32'h07ff_07ff;
      end else if (paddr == `YOF_WINV_OFS) begin
        winv_q <= pwdata & 32'h07ff_07ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // active-video strobe generation
  reg [63:0] strobe_sr_q;
  reg [10:0] hcnt_q;
  reg [10:0] vcnt_q;
  wire win_av;
  wire delayed_av;
  wire av_src;

  // input strobe delay line, tap 0 is one register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_sr_q <= 64'h0000_0000_0000_0000;
    end else begin
      strobe_sr_q <= {strobe_sr_q[62:0], active_video_in};
    end
  end
  assign delayed_av = strobe_sr_q[out_strobe_delay];

  // pixel and line counters for the window
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_q <= 11'h000;
      vcnt_q <= 11'h000;
    end else begin
      if (line_start_in) begin
        hcnt_q <= 11'h000;
      end else if (hcnt_q != 11'h7ff) begin
        hcnt_q <= hcnt_q + 11'h001;
      end
      if (field_start_in) begin
        vcnt_q <= 11'h000;
      end else if (line_start_in && vcnt_q != 11'h7ff) begin
        vcnt_q <= vcnt_q + 11'h001;
      end
    end
  end
  assign win_av = (hcnt_q >= h_start) && (hcnt_q < h_stop) &&
                  (vcnt_q >= v_start) && (vcnt_q < v_stop);
  assign av_src = out_strobe_mode_sel ? win_av : delayed_av;

  ////////////////////////////////////////////////////////////////////
  // chroma pipeline: c = newest, p1 and p2 older samples
  reg [7:0] y_c_q, y_p1_q;
  reg [7:0] u_c_q, u_p1_q, u_p2_q;
  reg [7:0] v_c_q, v_p1_q, v_p2_q;
  reg av_p1_q;
  reg [1:0] phase_q;
  reg line_odd_q;
  reg [7:0] iu_q, iv_q;
  wire [8:0] u_sum = {u_p1_q[7], u_p1_q} + {u_c_q[7], u_c_q};
  wire [8:0] v_sum = {v_p1_q[7], v_p1_q} + {v_c_q[7], v_c_q};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y_c_q <= 8'h00;
      y_p1_q <= 8'h00;
      u_c_q <= 8'h00;
      u_p1_q <= 8'h00;
      u_p2_q <= 8'h00;
      v_c_q <= 8'h00;
      v_p1_q <= 8'h00;
      v_p2_q <= 8'h00;
      av_p1_q <= 1'b0;
    end else begin
      y_c_q <= luma_in;
      y_p1_q <= y_c_q;
      u_c_q <= u_in;
      u_p1_q <= u_c_q;
      u_p2_q <= u_p1_q;
      v_c_q <= v_in;
      v_p1_q <= v_c_q;
      v_p2_q <= v_p1_q;
      av_p1_q <= av_src;
    end
  end

  // multiplex phase restarts at every strobe rise; legacy line parity
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 2'h0;
      line_odd_q <= 1'b0;
      iu_q <= 8'h00;
      iv_q <= 8'h00;
    end else begin
      // first active sample of a line carries phase 0
      if (av_src && !av_p1_q) begin
        phase_q <= 2'h0;
      end else begin
        phase_q <= phase_q + 2'h1;
      end
      if (field_start_in) begin
        line_odd_q <= 1'b0;
      end else if (line_start_in) begin
        line_odd_q <= ~line_odd_q;
      end
      // skew-corrected mid-point chroma, latched per group
      if ((av_src && !av_p1_q) ||
          (fmt == `YOF_FMT_ORT422 ? phase_q[0] : phase_q == 2'h3)) begin
        iu_q <= u_sum[8:1];
        iv_q <= v_sum[8:1];
      end
    end
  end

  // chroma selection per format; phase of current output sample
  reg [7:0] ch_raw_d;
  reg [7:0] nib_u_d;
  always @* begin
    ch_raw_d = 8'h00;
    nib_u_d = 8'h00;
    case (fmt)
      `YOF_FMT_ORT422: begin
        // U on even, held V on odd samples
        ch_raw_d = phase_q[0] ? iv_q : iu_q;
      end
      `YOF_FMT_ORT411: begin
        // bit pairs msb first, U on [3:2], V on [1:0]
        nib_u_d = iu_q << {phase_q, 1'b0};
        ch_raw_d = {4'h0, nib_u_d[7:6], 2'h0};
        nib_u_d = iv_q << {phase_q, 1'b0};
        ch_raw_d = {4'h0, ch_raw_d[3:2], nib_u_d[7:6]};
      end
      default: begin
        // next pixel's V, then previous pixel's U, swapped on odd lines
        if (!phase_q[0]) begin
          ch_raw_d = line_odd_q ? u_c_q : v_c_q;
        end else begin
          ch_raw_d = line_odd_q ? v_p2_q : u_p2_q;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // code levels and sign format
  wire [8:0] y_shift = {1'b0, y_p1_q} +
                       (black_shift ? {1'b0, `YOF_BLACK_STEP} : 9'h000);
  wire [7:0] y_min = legacy_lvl ? `YOF_LEG_Y_MIN : `YOF_STD_Y_MIN;
  wire [7:0] y_max = legacy_lvl ? `YOF_LEG_Y_MAX : `YOF_STD_Y_MAX;
  wire [7:0] c_lim = legacy_lvl ? `YOF_LEG_C_LIM : `YOF_STD_C_LIM;
  wire [7:0] c_neg = 8'h00 - c_lim;
  wire is_411 = (fmt == `YOF_FMT_ORT411);
  reg [7:0] y_lvl_d;
  reg [7:0] c_lvl_d;

  always @* begin
    // luma clip, black moved 16 to 32 when shifted
    if (y_shift[8] || y_shift[7:0] > y_max) begin
      y_lvl_d = y_max;
    end else if (y_shift[7:0] < y_min) begin
      y_lvl_d = y_min;
    end else begin
      y_lvl_d = y_shift[7:0];
    end
    // signed chroma clip round bias 0
    if (is_411) begin
      c_lvl_d = ch_raw_d;
    end else if (!ch_raw_d[7] && ch_raw_d > c_lim) begin
      c_lvl_d = c_lim;
    end else if (ch_raw_d[7] && ch_raw_d < c_neg) begin
      c_lvl_d = c_neg;
    end else begin
      c_lvl_d = ch_raw_d;
    end
    // offset binary flips the sign bit
    if (offset_bin && !is_411) begin
      c_lvl_d = c_lvl_d ^ `YOF_SIGN_FLIP;
    end
  end

  // blanking forces clamp level and bias
  wire [7:0] bias_code = offset_bin ? `YOF_SIGN_FLIP : 8'h00;
  wire [7:0] clamp_y = black_shift ? `YOF_LEG_Y_MIN : y_min;
  wire [7:0] y_fmt = av_p1_q ? y_lvl_d : clamp_y;
  wire [7:0] c_fmt = av_p1_q ? c_lvl_d : (is_411 ? 8'h00 : bias_code);

  ////////////////////////////////////////////////////////////////////
  // data lag behind the strobe by the advance setting
  reg [15:0] lag_q [0:3];
  wire [15:0] data_tap;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lag
      if (gi == 0) begin : g_head
        // first stage takes the formatted word
        always @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            lag_q[gi] <= 16'h0000;
          end else begin
            lag_q[gi] <= {y_fmt, c_fmt};
          end
        end
      end else begin : g_tail
        // later stages pass the word on by one clock
        always @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            lag_q[gi] <= 16'h0000;
          end else begin
            lag_q[gi] <= lag_q[gi - 1];
          end
        end
      end
    end
  endgenerate
  assign data_tap = out_strobe_advance == 2'h0 ? {y_fmt, c_fmt} :
                    lag_q[out_strobe_advance - 2'h1];

  ////////////////////////////////////////////////////////////////////
  // priority arbitration and registered outputs
  // request: enable gate, source zero only in active video
  wire req_d = priority_request_enable &&
               (priority_request_source || av_p1_q);
  // won when the bus reads back our own id this cycle
  wire won = priority_bus_oe && (priority_bus_in == priority_bus_out);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      priority_bus_out <= 3'h0;
      priority_bus_oe <= 1'b0;
      granted_q <= 1'b0;
      pixel_oe <= 1'b0;
      pixel_half_drive <= 1'b0;
      luma_out_bus <= 8'h00;
      chroma_out_bus <= 8'h00;
      active_video_out <= 1'b0;
    end else begin
      priority_bus_out <= bus_id;
      priority_bus_oe <= req_d;
      granted_q <= won;
      pixel_oe <= won;
      pixel_half_drive <= ctrl_q[`YOF_HALF_DRIVE_BIT];
      luma_out_bus <= data_tap[15:8];
      chroma_out_bus <= data_tap[7:0];
      active_video_out <= av_p1_q ^ out_strobe_polarity;
    end
  end

endmodule

// ==== tb/yof_bus_peer.sv ====
// peer source on the shared priority bus, with its arbiter
// assumes every source runs on pclk; an idle bus is pulled up
`timescale 1ns/10ps
module yof_bus_peer (
  input wire pclk,
  input wire own_oe,
  input wire [2:0] own_id,
  input wire peer_req,
  input wire [2:0] peer_id,
  output logic [2:0] bus
);
  logic req_q;
  // peer request changes only on the shared clock
  always @(posedge pclk) begin
    req_q <= peer_req;
  end
  // highest requesting id wins the cycle, read back at once
  always_comb begin
    if (own_oe && req_q) begin
      bus = (own_id > peer_id) ? own_id : peer_id;
    end else if (own_oe) begin
      bus = own_id;
    end else if (req_q) begin
      bus = peer_id;
    end else begin
      bus = 3'h7;
    end
  end
endmodule

// ==== tb/yof_chk.sv ====
// checker for the formatter: apb answer, arbitration and drive
// assumes it is bound to the formatter and sees only its ports
`timescale 1ns/10ps
`include "yof_regs.vh"
module yof_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [2:0] priority_bus_in,
  input wire [2:0] priority_bus_out,
  input wire priority_bus_oe,
  input wire pixel_oe,
  input wire pixel_half_drive,
  input wire [7:0] luma_out_bus
);
  logic [31:0] ctrl_q;
  // shadow of the control word from completed writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= 32'h0;
    else if (psel && penable && pready && pwrite && !pslverr &&
        paddr == `YOF_CTRL_OFS) ctrl_q <= pwdata;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_won;
    priority_bus_oe && priority_bus_in == priority_bus_out;
  endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_once; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_grant; s_won |=> pixel_oe; endproperty
  property p_lose;
    !(priority_bus_oe && priority_bus_in == priority_bus_out) |=> !pixel_oe;
  endproperty
  property p_noreq; (!ctrl_q[8]) [*2] |-> !priority_bus_oe; endproperty
  property p_cont;
    (ctrl_q[8] && ctrl_q[9]) [*2] |->
      priority_bus_oe && priority_bus_out == ctrl_q[14:12];
  endproperty
  property p_half;
    ctrl_q[5] == $past(ctrl_q[5]) |-> pixel_half_drive == ctrl_q[5];
  endproperty
  property p_luma;
    pixel_oe |-> luma_out_bus >= 8'h10 && luma_out_bus <= 8'hf0;
  endproperty
  a_ready: assert property (p_ready) else $error("setup not answered");
  a_once: assert property (p_once) else $error("ready held");
  a_err: assert property (p_err) else $error("error without ready");
  a_grant: assert property (p_grant) else $error("win not granted");
  a_lose: assert property (p_lose) else $error("drive without win");
  a_noreq: assert property (p_noreq) else $error("request off");
  a_cont: assert property (p_cont) else $error("no steady request");
  a_half: assert property (p_half) else $error("half drive");
  a_luma: assert property (p_luma) else $error("luma range");
endmodule
bind yof_formatter yof_chk u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .priority_bus_in,
  .priority_bus_out, .priority_bus_oe, .pixel_oe, .pixel_half_drive,
  .luma_out_bus);

// ==== tb/tb_top.sv ====
// testbench for the formatter: registers, strobe, formats, arbitration
// assumes the checker is bound and the peer model drives the bus
`timescale 1ns/10ps
`include "yof_regs.vh"
module tb_top;
  localparam logic [31:0] CS = 32'h3300;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, vid_in = 0, lsi = 0, fsi = 0, peer_req = 0;
  logic [7:0] luma_in = 8'h0, u_in = 8'h0, v_in = 8'h0, luma_o, chroma_o;
  logic [2:0] pbus, pid, peer_id = 3'h0;
  logic poe, pix_oe, half, vid_out;
  int num_errors = 0, compares = 0;
  // pixel clock
  always #2.5 pclk = ~pclk;
  yof_formatter DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .luma_in, .u_in, .v_in,
    .active_video_in(vid_in), .line_start_in(lsi), .field_start_in(fsi),
    .priority_bus_in(pbus), .priority_bus_out(pid), .priority_bus_oe(poe),
    .luma_out_bus(luma_o), .chroma_out_bus(chroma_o), .pixel_oe(pix_oe),
    .pixel_half_drive(half), .active_video_out(vid_out));
  yof_bus_peer PEER (.pclk, .own_oe(poe), .own_id(pid), .peer_req,
    .peer_id, .bus(pbus));
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 4; i++) begin
      apb(0, 12'(i * 4), 32'h0, r, e);
      chk(r, 32'h0);
    end
    apb(0, 12'h020, 32'h0, r, e);
    chk(r, 32'h0);
    chk(e, 1);
    wr(`YOF_CTRL_OFS, 32'h20);
    repeat (3) @(negedge pclk);
    chk(half, 1);
  endtask
  task automatic t_strobe(input int d, input logic [31:0] ctl, input int x);
    int n;
    wr(`YOF_CTRL_OFS, ctl);
    wr(`YOF_STRB_OFS, d);
    repeat (70) @(negedge pclk);
    chk(vid_out, ctl[6]);
    @(posedge pclk);
    vid_in <= 1;
    n = 0;
    while (vid_out === ctl[6] && n < 80) begin
      @(negedge pclk);
      n++;
    end
    // first negedge falls half a cycle after the driving edge
    chk(n - 1, x);
    @(posedge pclk);
    vid_in <= 0;
  endtask
  // window strobe: columns 4..7 of line 0 only, lagging two clocks
  task automatic t_win();
    int first;
    int cnt;
    wr(`YOF_WINH_OFS, 32'h0008_0004);
    wr(`YOF_WINV_OFS, 32'h0001_0000);
    wr(`YOF_CTRL_OFS, 32'h80);
    for (int l = 0; l < 2; l++) begin
      @(posedge pclk);
      fsi <= (l == 0);
      lsi <= 1;
      @(posedge pclk);
      fsi <= 0;
      lsi <= 0;
      first = 0;
      cnt = 0;
      for (int k = 0; k < 14; k++) begin
        @(negedge pclk);
        if (vid_out === 1'b1) begin
          if (cnt == 0) first = k;
          cnt++;
        end
      end
      chk(first, (l == 0) ? 6 : 0);
      chk(cnt, (l == 0) ? 4 : 0);
    end
  endtask
  task automatic t_fmt(input logic [31:0] ctl, input logic [1:0] adv,
      input logic [7:0] y, u, v, ey, ek, ec, input logic [31:0] c4,
      output logic [7:0] first);
    int n;
    wr(`YOF_CTRL_OFS, ctl);
    wr(`YOF_STRB_OFS, {22'h0, adv, 8'h0});
    luma_in <= y;
    u_in <= u;
    v_in <= v;
    repeat (8) @(negedge pclk);
    if (ctl[9]) chk({luma_o, chroma_o}, {ek, ec});
    else chk({poe, pix_oe}, 0);
    @(posedge pclk);
    fork
      begin
        vid_in <= 1;
        lsi <= 1;
        @(posedge pclk);
        lsi <= 0;
        repeat (7) @(posedge pclk);
        vid_in <= 0;
        repeat (8) @(posedge pclk);
      end
      begin
        n = 0;
        while (vid_out !== 1'b1 && n < 40) begin
          @(negedge pclk);
          n++;
        end
        repeat (adv) @(negedge pclk);
        first = chroma_o;
        for (int k = 0; k < 4; k++) begin
          if (ctl[9]) chk(luma_o, ey);
          if (c4 != 0) chk(chroma_o, c4[31 - 8 * k -: 8]);
          if (ctl[9] || k == 3) chk(pix_oe, 1);
          @(negedge pclk);
        end
      end
    join
  endtask
  task automatic t_arb();
    logic [31:0] r;
    logic e;
    wr(`YOF_CTRL_OFS, CS | 1);
    peer_id <= 3'h5;
    peer_req <= 1;
    repeat (4) @(negedge pclk);
    chk({pid, poe, pix_oe}, {3'h3, 2'b10});
    @(posedge pclk);
    peer_id <= 3'h2;
    repeat (4) @(negedge pclk);
    chk(pix_oe, 1);
    // status: bus reads id 3, strobe low, grant held
    apb(0, `YOF_STAT_OFS, 32'h0, r, e);
    chk(r, 32'h0000_000d);
    @(posedge pclk);
    peer_req <= 0;
    wr(`YOF_CTRL_OFS, 32'h0);
    repeat (4) @(negedge pclk);
    chk(poe, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    finish_test();
  end
  // main sequence
  initial begin
    logic [7:0] f1, f2;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_strobe(0, 32'h0, 3);
    t_strobe(63, 32'h40, 66);
    t_win();
    t_fmt(CS | 1, 0, 8'h50, 8'h11, 8'hf0, 8'h50, 8'h10, 8'h00,
      32'h11f011f0, f1);
    t_fmt(CS | 5, 0, 8'h50, 8'h11, 8'hf0, 8'h60, 8'h20, 8'h00,
      32'h11f011f0, f1);
    t_fmt(CS | 1, 0, 8'hf8, 8'h7f, 8'h81, 8'hf0, 8'h10, 8'h00,
      32'h70907090, f1);
    t_fmt(CS | 9, 0, 8'hc0, 8'h7f, 8'h81, 8'h7f, 8'h20, 8'h00,
      32'h7f817f81, f1);
    t_fmt(CS | 17, 0, 8'h50, 8'h11, 8'hf0, 8'h50, 8'h10, 8'h80,
      32'h91709170, f1);
    t_fmt(CS | 2, 2, 8'h50, 8'hb4, 8'h1e, 8'h50, 8'h10, 8'h00,
      32'h080d0702, f1);
    t_fmt(32'h3101, 0, 8'h50, 8'h11, 8'hf0, 8'h50, 8'h10, 8'h00,
      32'h0, f1);
    t_fmt(CS, 0, 8'h50, 8'h11, 8'hf0, 8'h50, 8'h10, 8'h00, 32'h0, f1);
    t_fmt(CS, 0, 8'h50, 8'h11, 8'hf0, 8'h50, 8'h10, 8'h00, 32'h0, f2);
    chk(f1 ^ f2, 8'he1);
    t_arb();
    finish_test();
  end
endmodule
